/* pbc_pkg.sv */
// package: constants for the peer register broadcast block
package pbc_pkg;
   // ----------------------------------------
   // register indices (word addresses)
   // ----------------------------------------
   localparam logic [15:0] PKT_LO_IDX   = 16'h0810;
   localparam logic [15:0] PKT_HI_IDX   = 16'h0811;
   localparam logic [15:0] COLL_A_IDX   = 16'h0812;
   localparam logic [15:0] COLL_B_IDX   = 16'h0813;
   localparam logic [15:0] ACTIVE_IDX   = 16'h0CE7;
   localparam logic [15:0] INTERVAL_IDX = 16'h1F4B;
   localparam logic [15:0] OWN_NODE_IDX = 16'h1F4C;
   localparam logic [15:0] TX_START_IDX = 16'h1F4D;
   localparam logic [15:0] NODE_CNT_IDX = 16'h1F5A;
   localparam logic [15:0] TX_LEN_IDX   = 16'h1F5B;
   localparam logic [15:0] DEST_IDX     = 16'h1F5C;
   localparam logic [15:0] OPTIONS_IDX  = 16'h1F5E;
   // mailbox occupies indices 1..2048
   localparam logic [15:0] MBOX_FIRST   = 16'h0001;
   localparam logic [15:0] MBOX_LAST    = 16'h0800;
   localparam int          MBOX_DEPTH   = 2048;
   // ----------------------------------------
   // fields and limits
   // ----------------------------------------
   localparam int          PEER_EN_BIT  = 6;
   localparam logic [15:0] MAX_BLOCK    = 16'h0080;
   localparam int          ACT_NODES    = 16;
   localparam logic [15:0] FRAME_TAG    = 16'hA5C3; // arbitrary multicast marker
   localparam logic [15:0] CFG_RESET    = 16'h0000;
   localparam logic [1:0]  AGE_LIMIT    = 2'h3;     // intervals before absent
   // ----------------------------------------
   // timing
   // ----------------------------------------
   localparam int          CLK_NS       = 20;
   localparam int          MS_NS        = 1000000;
   localparam int          MS_CYCLES    = MS_NS / CLK_NS;
endpackage : pbc_pkg

/* pbc_cfg_if.sv */
// interface: configuration and timing between the block's own modules
`timescale 1ns/1ps
`default_nettype none
interface pbc_cfg_if;
   logic        enable;     // peer operation on
   logic [15:0] own_node;   // this node's number
   logic [15:0] node_count; // transmitting nodes
   logic [15:0] interval;   // update interval, ms
   logic        ms_tick;    // one pulse per ms
   logic        tx_start;   // slot reached
   logic        heard;      // frame accepted from a peer
   logic [15:0] heard_node; // sender of that frame
   logic [15:0] active;     // activity bitmap
   modport top   (output enable, own_node, node_count, interval, heard, heard_node,
                  input ms_tick, tx_start, active);
   modport timer (input enable, own_node, node_count, interval,
                  output ms_tick, tx_start);
   modport act   (input enable, interval, ms_tick, heard, heard_node, output active);
endinterface : pbc_cfg_if
`default_nettype wire

/* pbc_slot_timer.sv */
// module: millisecond tick and per-node slot scheduler
`timescale 1ns/1ps
`default_nettype none
module pbc_slot_timer #(
   parameter logic [15:0] MS_CYCLES = 16'(pbc_pkg::MS_CYCLES)
) (
   input  wire logic sys_clk_in, // system clock
   input  wire logic rst_in,     // async reset, high
   pbc_cfg_if.timer  cfg         // config and timing
);
   logic [15:0] cyc;
   logic [15:0] ms;
   logic [31:0] prod;
   logic [15:0] slot_off;
   logic        may_send;
   logic        ms_wrap;

   // ----------------------------------------
   // slot offset
   // ----------------------------------------
   // slot sits (node-1)*interval/count into each interval
   assign prod     = 32'(cfg.own_node - 16'h0001) * 32'(cfg.interval);
   assign slot_off = (cfg.node_count == 16'h0000) ? 16'h0000
                   : 16'(prod / 32'(cfg.node_count));
   // listen-only (node 0) never gets a slot
   assign may_send = cfg.enable && (cfg.own_node != 16'h0000)
                   && (cfg.own_node <= cfg.node_count)
                   && (cfg.interval != 16'h0000);
   assign ms_wrap  = (ms >= cfg.interval - 16'h0001);

   // ms divider and interval position; free running so a lost peer cannot shift us
   always_ff @(posedge sys_clk_in or posedge rst_in)
   begin
      if (rst_in)
      begin
         cyc          <= 16'h0000;
         ms           <= 16'h0000;
         cfg.ms_tick  <= 1'b0;
         cfg.tx_start <= 1'b0;
      end
      else
      begin
         cfg.ms_tick  <= (cyc == MS_CYCLES - 16'h0001);
         cyc          <= (cyc == MS_CYCLES - 16'h0001) ? 16'h0000 : cyc + 16'h0001;
         if (cfg.ms_tick)
            ms <= ms_wrap ? 16'h0000 : ms + 16'h0001;
         cfg.tx_start <= cfg.ms_tick && may_send && (ms == slot_off);
      end
   end

   // ----------------------------------------
   // checks
   // ----------------------------------------
   start_gated_a : assert property (@(posedge sys_clk_in) disable iff (rst_in)
      cfg.tx_start |-> $past(may_send))
      else $error("slot start without permission");
   start_on_tick_a : assert property (@(posedge sys_clk_in) disable iff (rst_in)
      cfg.tx_start |-> $past(cfg.ms_tick))
      else $error("slot start off the ms tick");
endmodule : pbc_slot_timer
`default_nettype wire

/* pbc_activity.sv */
// module: per-node activity bitmap with absence timeout
`timescale 1ns/1ps
`default_nettype none
module pbc_activity (
   input  wire logic sys_clk_in, // system clock
   input  wire logic rst_in,     // async reset, high
   pbc_cfg_if.act    cfg         // config and events
);
   genvar g;
   // one age counter per node 1..16; nodes 17 and up get none
   generate
      for (g = 0; g < pbc_pkg::ACT_NODES; g++)
      begin : g_node
         logic [1:0] age;
         logic       hit;
         assign hit = cfg.heard && (cfg.heard_node == 16'(g + 1));
         // age in whole intervals; a wrap of ms count equals one interval
         logic [15:0] ms_in;
         always_ff @(posedge sys_clk_in or posedge rst_in)
         begin
            if (rst_in)
            begin
               age           <= 2'h0;
               ms_in         <= 16'h0000;
               cfg.active[g] <= 1'b0;
            end
            else if (!cfg.enable)
            begin
               age           <= 2'h0;
               ms_in         <= 16'h0000;
               cfg.active[g] <= 1'b0;
            end
            else if (hit)
            begin
               age           <= 2'h0;
               ms_in         <= 16'h0000;
               cfg.active[g] <= 1'b1;
            end
            else if (cfg.ms_tick)
            begin
               if (ms_in >= cfg.interval - 16'h0001)
               begin
                  ms_in <= 16'h0000;
                  if (age == pbc_pkg::AGE_LIMIT - 2'h1)
                     cfg.active[g] <= 1'b0;
                  else
                     age <= age + 2'h1;
               end
               else
                  ms_in <= ms_in + 16'h0001;
            end
         end
         heard_sets_a : assert property (@(posedge sys_clk_in) disable iff (rst_in)
            cfg.enable && hit |=> cfg.active[g])
            else $error("heard node not marked active");
      end
   endgenerate
endmodule : pbc_activity
`default_nettype wire

/* pbc_peer_broadcast.sv */
// module: top of the peer register broadcast block
`timescale 1ns/1ps
`default_nettype none
module pbc_peer_broadcast #(
   parameter logic [15:0] MS_CYCLES = 16'(pbc_pkg::MS_CYCLES) // cycles per ms
) (
   input  wire logic        sys_clk_in,    // 50 MHz clock
   input  wire logic        rst_in,        // async reset, high
   input  wire logic [15:0] reg_addr_in,   // register index
   input  wire logic        reg_wr_in,     // write strobe
   input  wire logic        reg_rd_in,     // read strobe
   input  wire logic [15:0] reg_wdata_in,  // write data
   output logic      [15:0] reg_rdata_out, // read data, next cycle
   output logic             tx_valid_out,  // frame word valid
   output logic      [15:0] tx_data_out,   // frame word
   output logic             tx_last_out,   // last word of frame
   input  wire logic        tx_ready_in,   // mac takes word
   input  wire logic        rx_valid_in,   // received word valid
   input  wire logic [15:0] rx_data_in,    // received word
   input  wire logic        rx_last_in,    // last received word
   input  wire logic        coll_in,       // collision pulse
   input  wire logic        coll_abort_in, // excess collision pulse
   input  wire logic        other_req_in,  // other traffic wants the mac
   output logic             other_gnt_out, // other traffic may send
   output logic             poll_ok_out    // timed polling permitted
);
   typedef enum logic [2:0] {T_IDLE, T_TAG, T_NODE, T_DEST, T_CNT, T_DATA} pbc_tx_type;
   typedef enum logic [2:0] {R_IDLE, R_NODE, R_DEST, R_CNT, R_DATA} pbc_rx_type;

   pbc_cfg_if cfg ();

   logic [15:0] mbox [pbc_pkg::MBOX_DEPTH];
   logic [15:0] interval, own_node, tx_first, node_count, tx_len, dest, options;
   logic [31:0] pkt_cnt;
   logic [15:0] coll_a, coll_b;
   pbc_tx_type  tx_st;
   pbc_rx_type  rx_st;
   logic [15:0] tx_idx, tx_n;
   logic [15:0] rx_node, rx_dest, rx_cnt, rx_idx;
   logic        tx_pend;

   // ----------------------------------------
   // decode
   // ----------------------------------------
   function automatic logic is_mbox(input logic [15:0] a);
      return (a >= pbc_pkg::MBOX_FIRST) && (a <= pbc_pkg::MBOX_LAST);
   endfunction : is_mbox

   wire         peer_en  = options[pbc_pkg::PEER_EN_BIT];
   wire         len_ok   = (tx_len != 16'h0000) && (tx_len <= pbc_pkg::MAX_BLOCK);
   wire         tx_go    = tx_valid_out && tx_ready_in;
   wire         rx_take  = rx_valid_in && peer_en;
   wire [15:0]  tx_addr  = tx_first + tx_idx - pbc_pkg::MBOX_FIRST;
   wire [15:0]  rx_addr  = rx_dest + rx_idx - pbc_pkg::MBOX_FIRST;
   wire         rx_wr    = rx_take && (rx_st == R_DATA) && is_mbox(rx_dest + rx_idx);
   wire         rx_done  = rx_take && (rx_st == R_DATA) && rx_last_in
                         && (rx_idx == rx_cnt - 16'h0001);
   wire         frame_end = tx_go && tx_last_out;
   wire         tx_busy  = (tx_st != T_IDLE) || tx_pend;
   wire [15:0]  mbox_q   = mbox[tx_addr[10:0]];

   assign cfg.enable     = peer_en;
   assign cfg.own_node   = own_node;
   assign cfg.node_count = node_count;
   assign cfg.interval   = interval;
   assign cfg.heard      = rx_done;
   assign cfg.heard_node = rx_node;

   pbc_slot_timer #(.MS_CYCLES(MS_CYCLES)) u_timer (
      .sys_clk_in (sys_clk_in),
      .rst_in     (rst_in),
      .cfg        (cfg)
   );

   pbc_activity u_act (
      .sys_clk_in (sys_clk_in),
      .rst_in     (rst_in),
      .cfg        (cfg)
   );

   // ----------------------------------------
   // setup registers and mailbox
   // ----------------------------------------
   // received blocks win over a software write in the same cycle
   always_ff @(posedge sys_clk_in)
   begin
      if (rx_wr)
         mbox[rx_addr[10:0]] <= rx_data_in;
      else if (reg_wr_in && is_mbox(reg_addr_in))
         mbox[reg_addr_in[10:0] - 11'h001] <= reg_wdata_in;
   end

   always_ff @(posedge sys_clk_in or posedge rst_in)
   begin
      if (rst_in)
      begin
         interval   <= pbc_pkg::CFG_RESET;
         own_node   <= pbc_pkg::CFG_RESET;
         tx_first   <= pbc_pkg::CFG_RESET;
         node_count <= pbc_pkg::CFG_RESET;
         tx_len     <= pbc_pkg::CFG_RESET;
         dest       <= pbc_pkg::CFG_RESET;
         options    <= pbc_pkg::CFG_RESET;
      end
      else if (reg_wr_in)
      begin
         unique case (reg_addr_in)
            pbc_pkg::INTERVAL_IDX : interval   <= reg_wdata_in;
            pbc_pkg::OWN_NODE_IDX : own_node   <= reg_wdata_in;
            pbc_pkg::TX_START_IDX : tx_first   <= reg_wdata_in;
            pbc_pkg::NODE_CNT_IDX : node_count <= reg_wdata_in;
            pbc_pkg::TX_LEN_IDX   : tx_len     <= reg_wdata_in;
            pbc_pkg::DEST_IDX     : dest       <= reg_wdata_in;
            pbc_pkg::OPTIONS_IDX  : options    <= reg_wdata_in;
            default               : ;
         endcase
      end
   end

   // read port; unmapped indices read zero
   always_ff @(posedge sys_clk_in or posedge rst_in)
   begin
      if (rst_in)
         reg_rdata_out <= 16'h0000;
      else if (reg_rd_in)
      begin
         unique case (reg_addr_in)
            pbc_pkg::PKT_LO_IDX   : reg_rdata_out <= pkt_cnt[15:0];
            pbc_pkg::PKT_HI_IDX   : reg_rdata_out <= pkt_cnt[31:16];
            pbc_pkg::COLL_A_IDX   : reg_rdata_out <= coll_a;
            pbc_pkg::COLL_B_IDX   : reg_rdata_out <= coll_b;
            pbc_pkg::ACTIVE_IDX   : reg_rdata_out <= cfg.active;
            pbc_pkg::INTERVAL_IDX : reg_rdata_out <= interval;
            pbc_pkg::OWN_NODE_IDX : reg_rdata_out <= own_node;
            pbc_pkg::TX_START_IDX : reg_rdata_out <= tx_first;
            pbc_pkg::NODE_CNT_IDX : reg_rdata_out <= node_count;
            pbc_pkg::TX_LEN_IDX   : reg_rdata_out <= tx_len;
            pbc_pkg::DEST_IDX     : reg_rdata_out <= dest;
            pbc_pkg::OPTIONS_IDX  : reg_rdata_out <= options;
            default : reg_rdata_out <= is_mbox(reg_addr_in)
                                     ? mbox[reg_addr_in[10:0] - 11'h001] : 16'h0000;
         endcase
      end
   end

   // ----------------------------------------
   // statistics
   // ----------------------------------------
   // packets counted both ways; counters wrap
   always_ff @(posedge sys_clk_in or posedge rst_in)
   begin
      if (rst_in)
      begin
         pkt_cnt <= 32'h0000_0000;
         coll_a  <= 16'h0000;
         coll_b  <= 16'h0000;
      end
      else
      begin
         pkt_cnt <= pkt_cnt + 32'(frame_end) + 32'(rx_done);
         coll_a  <= coll_a + 16'(coll_in);
         coll_b  <= coll_b + 16'(coll_abort_in);
      end
   end

   // ----------------------------------------
   // transmit: tag, node, dest, count, data
   // ----------------------------------------
   // a slot held pending until the grant to other traffic (other_gnt_out) is low
   always_ff @(posedge sys_clk_in or posedge rst_in)
   begin
      if (rst_in)
      begin
         tx_st        <= T_IDLE;
         tx_pend      <= 1'b0;
         tx_idx       <= 16'h0000;
         tx_n         <= 16'h0000;
         tx_valid_out <= 1'b0;
         tx_data_out  <= 16'h0000;
         tx_last_out  <= 1'b0;
      end
      else
      begin
         // a pending slot is dropped when peer operation is switched off
         if (!peer_en)
            tx_pend <= 1'b0;
         else if (cfg.tx_start && len_ok)
            tx_pend <= 1'b1;
         unique case (tx_st)
            T_IDLE :
               if (tx_pend && peer_en && len_ok && !other_gnt_out)
               begin
                  tx_pend      <= 1'b0;
                  tx_n         <= tx_len;
                  tx_idx       <= 16'h0000;
                  tx_valid_out <= 1'b1;
                  tx_data_out  <= pbc_pkg::FRAME_TAG;
                  tx_st        <= T_TAG;
               end
            T_TAG :
               if (tx_ready_in)
               begin
                  tx_data_out <= own_node;
                  tx_st       <= T_NODE;
               end
            T_NODE :
               if (tx_ready_in)
               begin
                  tx_data_out <= dest;
                  tx_st       <= T_DEST;
               end
            T_DEST :
               if (tx_ready_in)
               begin
                  tx_data_out <= tx_n;
                  tx_st       <= T_CNT;
               end
            T_CNT, T_DATA :
               if (tx_ready_in)
               begin
                  if (tx_last_out)
                  begin
                     // no acknowledgement awaited
                     tx_valid_out <= 1'b0;
                     tx_last_out  <= 1'b0;
                     tx_st        <= T_IDLE;
                  end
                  else
                  begin
                     tx_data_out <= mbox_q;
                     tx_last_out <= (tx_idx == tx_n - 16'h0001);
                     tx_idx      <= tx_idx + 16'h0001;
                     tx_st       <= T_DATA;
                  end
               end
         endcase
      end
   end

   // other traffic only while the broadcast path is idle
   always_ff @(posedge sys_clk_in or posedge rst_in)
   begin
      if (rst_in)
      begin
         other_gnt_out <= 1'b0;
         poll_ok_out   <= 1'b0;
      end
      else
      begin
         other_gnt_out <= other_req_in && !tx_busy && !cfg.tx_start;
         poll_ok_out   <= !peer_en;
      end
   end

   // ----------------------------------------
   // receive; frames ignored while disabled
   // ----------------------------------------
   always_ff @(posedge sys_clk_in or posedge rst_in)
   begin
      if (rst_in)
      begin
         rx_st   <= R_IDLE;
         rx_node <= 16'h0000;
         rx_dest <= 16'h0000;
         rx_cnt  <= 16'h0000;
         rx_idx  <= 16'h0000;
      end
      else if (rx_take)
      begin
         unique case (rx_st)
            R_IDLE :
               if (!rx_last_in && rx_data_in == pbc_pkg::FRAME_TAG)
                  rx_st <= R_NODE;
            R_NODE :
            begin
               rx_node <= rx_data_in;
               rx_st   <= R_DEST;
            end
            R_DEST :
            begin
               rx_dest <= rx_data_in;
               rx_st   <= R_CNT;
            end
            R_CNT  :
            begin
               rx_cnt <= rx_data_in;
               rx_idx <= 16'h0000;
               rx_st  <= R_DATA;
            end
            R_DATA : rx_idx <= rx_idx + 16'h0001;
         endcase
         // a short or stray frame ends on its last word
         if (rx_last_in)
            rx_st <= R_IDLE;
      end
      else if (!peer_en)
         rx_st <= R_IDLE;
   end

   // ----------------------------------------
   // checks
   // ----------------------------------------
   sequence frame_head;
      tx_valid_out && tx_data_out == pbc_pkg::FRAME_TAG && tx_st == T_TAG;
   endsequence
   no_tx_listen_a : assert property (@(posedge sys_clk_in) disable iff (rst_in)
      $rose(tx_valid_out) |-> own_node != 16'h0000)
      else $error("listen-only node transmitted");
   head_node_a : assert property (@(posedge sys_clk_in) disable iff (rst_in)
      frame_head ##0 tx_ready_in |=> (tx_data_out == own_node) && (tx_st == T_NODE))
      else $error("node word missing after tag");
   gnt_exclusive_a : assert property (@(posedge sys_clk_in) disable iff (rst_in)
      tx_valid_out |-> ##1 !other_gnt_out)
      else $error("other traffic granted during broadcast");
   slot_blocks_gnt_a : assert property (@(posedge sys_clk_in) disable iff (rst_in)
      cfg.tx_start |=> !other_gnt_out)
      else $error("other traffic granted at slot start");
   poll_off_a : assert property (@(posedge sys_clk_in) disable iff (rst_in)
      peer_en [*2] |-> !poll_ok_out)
      else $error("polling allowed while peer on");
   rx_ignore_a : assert property (@(posedge sys_clk_in) disable iff (rst_in)
      !peer_en |-> !rx_wr ##1 (rx_st == R_IDLE))
      else $error("receiver active while disabled");
   tx_hold_a : assert property (@(posedge sys_clk_in) disable iff (rst_in)
      tx_valid_out && !tx_ready_in |=> tx_valid_out && $stable(tx_data_out))
      else $error("frame word changed before it was taken");
   last_count_a : assert property (@(posedge sys_clk_in) disable iff (rst_in)
      tx_last_out |-> tx_valid_out && (tx_idx == tx_n) && (tx_n <= pbc_pkg::MAX_BLOCK))
      else $error("frame length does not match block length");
endmodule : pbc_peer_broadcast
`default_nettype wire

/* pbc_peer_model.sv */
// peer node model: takes frames from the block and sends frames to it
`timescale 1ns/1ps
`default_nettype none
module pbc_peer_model (
   input  wire logic        clk_in,       // system clock
   input  wire logic        slow_in,      // stall every other cycle
   input  wire logic        tx_valid_in,  // frame word valid
   input  wire logic [15:0] tx_data_in,   // frame word
   input  wire logic        tx_last_in,   // last word
   output logic             tx_ready_out, // word taken
   output logic             rx_valid_out, // word to block
   output logic      [15:0] rx_data_out,  // word to block
   output logic             rx_last_out   // last word to block
);
   logic [15:0] cap[$];
   int          last_at = 0;
   int          frames  = 0;
   initial
   begin
      tx_ready_out = 1'b0;
      rx_valid_out = 1'b0;
      rx_data_out = 16'h0000;
      rx_last_out = 1'b0;
   end
   // capture words; no reply frame ever follows
   always @(posedge clk_in)
   begin
      if (tx_valid_in && tx_ready_out)
      begin
         cap.push_back(tx_data_in);
         if (tx_last_in)
         begin
            last_at = cap.size();
            frames++;
         end
      end
      tx_ready_out <= #1 slow_in ? ~tx_ready_out : 1'b1;
   end
   // send one frame: marker, node, destination, count, data words
   task automatic send(input logic [15:0] node, dest, cnt, base);
      logic [15:0] w[$];
      w = {pbc_pkg::FRAME_TAG, node, dest, cnt};
      for (int i = 0; i < cnt; i++)
         w.push_back(base + 16'(i));
      foreach (w[i])
      begin
         @(posedge clk_in);
         #1;
         rx_valid_out = 1'b1;
         rx_data_out = w[i];
         rx_last_out = (i == w.size() - 1);
      end
      @(posedge clk_in);
      #1;
      rx_valid_out = 1'b0;
      rx_last_out = 1'b0;
      rx_data_out = ~rx_data_out; // released line shows no stale word
   endtask : send
endmodule : pbc_peer_model
`default_nettype wire

/* pbc_peer_broadcast_test.sv */
// self-checking bench for the peer register broadcast block
`timescale 1ns/1ps
`default_nettype none
module pbc_peer_broadcast_test;
   typedef struct {logic [15:0] a; logic [15:0] d; logic [15:0] e;} pbc_row_type;
   logic        clk = 1'b0, rst = 1'b1, wr_s = 1'b0, rd_s = 1'b0, slow = 1'b1;
   logic        coll = 1'b0, cab = 1'b0, oreq = 1'b1;
   logic [15:0] addr = 16'h0000, wdata = 16'h0000, rdata, txd, rxd;
   logic        txv, txl, txr, rxv, rxl, gnt, poll;
   int          err_count = 0, total_checks = 0, cyc = 0, t0;
   pbc_row_type rows[11] = '{'{pbc_pkg::INTERVAL_IDX, 16'h0002, 16'h0002},
      '{pbc_pkg::OWN_NODE_IDX, 16'h0001, 16'h0001}, '{pbc_pkg::TX_START_IDX, 16'h0005, 16'h0005},
      '{pbc_pkg::NODE_CNT_IDX, 16'h0002, 16'h0002}, '{pbc_pkg::TX_LEN_IDX, 16'h0003, 16'h0003},
      '{pbc_pkg::DEST_IDX, 16'h0020, 16'h0020}, '{16'h0005, 16'h0011, 16'h0011},
      '{16'h0006, 16'h0022, 16'h0022}, '{16'h0007, 16'h0033, 16'h0033},
      '{pbc_pkg::ACTIVE_IDX, 16'hFFFF, 16'h0000}, '{16'h1F00, 16'h5555, 16'h0000}};
   logic [15:0] exp_tx[7] = '{16'hA5C3, 16'h0001, 16'h0020, 16'h0003, 16'h0011, 16'h0022, 16'h0033};
   // clock and cycle count
   always #10 clk = ~clk;
   always @(posedge clk) cyc <= cyc + 1;
   pbc_peer_broadcast #(.MS_CYCLES(16'h0014)) pbc_peer_broadcast_i (.sys_clk_in(clk),
      .rst_in(rst), .reg_addr_in(addr), .reg_wr_in(wr_s), .reg_rd_in(rd_s),
      .reg_wdata_in(wdata), .reg_rdata_out(rdata), .tx_valid_out(txv), .tx_data_out(txd),
      .tx_last_out(txl), .tx_ready_in(txr), .rx_valid_in(rxv), .rx_data_in(rxd),
      .rx_last_in(rxl), .coll_in(coll), .coll_abort_in(cab), .other_req_in(oreq),
      .other_gnt_out(gnt), .poll_ok_out(poll));
   pbc_peer_model pbc_peer_model_i (.clk_in(clk), .slow_in(slow), .tx_valid_in(txv),
      .tx_data_in(txd), .tx_last_in(txl), .tx_ready_out(txr), .rx_valid_out(rxv),
      .rx_data_out(rxd), .rx_last_out(rxl));
   task automatic chk(input logic [15:0] got, exp);
      total_checks++;
      if (got !== exp)
      begin
         err_count++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk
   task automatic step;
      @(posedge clk);
      #1;
   endtask : step
   task automatic wr(input logic [15:0] a, d);
      step();
      addr = a;
      wdata = d;
      wr_s = 1'b1;
      step();
      wr_s = 1'b0;
   endtask : wr
   task automatic rd(input logic [15:0] a, e);
      step();
      addr = a;
      rd_s = 1'b1;
      step();
      rd_s = 1'b0;
      step();
      chk(rdata, e);
   endtask : rd
   // bounded wait for a frame start; a missing expected frame ends the run
   task automatic wait_tx(input logic want);
      int n;
      n = 0;
      while (txv !== 1'b1 && n < 200)
      begin
         step();
         n++;
      end
      chk(16'(txv === 1'b1), 16'(want));
      if (want && n == 200)
         give_verdict();
   endtask : wait_tx
   task automatic give_verdict;
      $display("checks %0d mismatches %0d", total_checks, err_count);
      if (err_count == 0 && total_checks > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask : give_verdict
   initial
   begin
      repeat (6) step();
      rst = 1'b0;
      step();
      chk(16'(poll), 16'h0001);
      foreach (rows[i])
      begin
         wr(rows[i].a, rows[i].d);
         rd(rows[i].a, rows[i].e);
      end
      chk(16'(gnt), 16'h0001);
      oreq = 1'b0;
      coll = 1'b1;
      step();
      chk(16'(gnt), 16'h0000);
      oreq = 1'b1;
      coll = 1'b0;
      cab = 1'b1;
      step();
      cab = 1'b0;
      rd(pbc_pkg::COLL_A_IDX, 16'h0001);
      rd(pbc_pkg::COLL_B_IDX, 16'h0001);
      $display("test done: registers");
      wr(pbc_pkg::OPTIONS_IDX, 16'h0040);
      step();
      chk(16'(poll), 16'h0000);
      wait_tx(1'b1);
      t0 = cyc;
      chk(16'(gnt), 16'h0000);
      for (int n = 0; n < 50 && txv === 1'b1; n++)
         step();
      chk(16'(txv), 16'h0000);
      foreach (exp_tx[i])
         chk(pbc_peer_model_i.cap[i], exp_tx[i]);
      chk(16'(pbc_peer_model_i.last_at), 16'h0007);
      // second frame with the far side taking a word every cycle
      slow = 1'b0;
      wait_tx(1'b1);
      chk(16'(cyc - t0), 16'h0028);
      for (int n = 0; n < 50 && txv === 1'b1; n++)
         step();
      chk(16'(txv), 16'h0000);
      foreach (exp_tx[i])
         chk(pbc_peer_model_i.cap[i + 7], exp_tx[i]);
      $display("test done: transmit");
      pbc_peer_model_i.send(16'h0002, 16'h0100, 16'h0002, 16'h0B00);
      rd(16'h0101, 16'h0B01);
      rd(pbc_pkg::ACTIVE_IDX, 16'h0002);
      pbc_peer_model_i.send(16'h0011, 16'h0200, 16'h0001, 16'h0C00);
      rd(16'h0200, 16'h0C00);
      rd(pbc_pkg::ACTIVE_IDX, 16'h0002);
      repeat (200) step();
      rd(pbc_pkg::ACTIVE_IDX, 16'h0000);
      $display("test done: receive");
      wr(pbc_pkg::OPTIONS_IDX, 16'h0000);
      // let a frame already on its way drain before checking silence
      repeat (20) step();
      wr(16'h0300, 16'h1234);
      pbc_peer_model_i.send(16'h0002, 16'h0300, 16'h0001, 16'h0D00);
      rd(16'h0300, 16'h1234);
      wait_tx(1'b0);
      wr(pbc_pkg::OWN_NODE_IDX, 16'h0000);
      wr(pbc_pkg::OPTIONS_IDX, 16'h0040);
      wait_tx(1'b0);
      pbc_peer_model_i.send(16'h0002, 16'h0300, 16'h0001, 16'h0D00);
      rd(16'h0300, 16'h0D00);
      // frames sent plus the three frames accepted from the far side
      rd(pbc_pkg::PKT_LO_IDX, 16'(pbc_peer_model_i.frames + 3));
      rd(pbc_pkg::PKT_HI_IDX, 16'h0000);
      $display("test done: disable and listen only");
      give_verdict();
   end
endmodule : pbc_peer_broadcast_test
`default_nettype wire
